/* File: pkg/ctis_map.vh */
// Register map, field positions, reset values and timing counts for the
// CPU throttle / idle / sleep controller.
// Assumes a byte-wide register port with small word addresses.
`ifndef CTIS_MAP_VH
`define CTIS_MAP_VH

// Register offsets (word addresses on the register port)
`define CTIS_ADDR_W          4
`define CTIS_OFF_REG_CTRL    4'h0
`define CTIS_OFF_THR_CTRL    4'h1
`define CTIS_OFF_STATUS      4'h2

// regulator_control fields
`define CTIS_REG_LP_BIT      1
`define CTIS_REG_RSVD_BIT    0
`define CTIS_REG_CTRL_RST    8'h01

// cpu_throttle_idle_control fields
`define CTIS_THR_IDLE_BIT    7
`define CTIS_THR_ACT_BIT     6
`define CTIS_THR_ROI_BIT     5
`define CTIS_THR_DOE_BIT     4
`define CTIS_THR_RATIO_HI    2
`define CTIS_THR_RATIO_LO    0
`define CTIS_THR_CTRL_RST    8'h00

// Status register fields
`define CTIS_ST_RUN_BIT      0
`define CTIS_ST_IDLE_BIT     1
`define CTIS_ST_SLEEP_BIT    2
`define CTIS_ST_WAKE_BIT     3
`define CTIS_ST_DBG_BIT      4

// Low-power wake stabilisation: 2000 ns at 40 ns a clock is 50 cycles
`define CTIS_LP_WAKE_CYC     8'h32

`endif

/* File: src/ctis_ctrl.v */
// CPU throttle, idle and sleep control: register file, sleep/idle state
// machine, low-power wake delay and CPU clock-enable throttling.
// Assumes the CPU core gives one-cycle pulses for sleep, interrupt entry,
// return-from-interrupt and wake events, all synchronous to clk.
//
// Function
// RQ1 - Low-power bit set: regulator low-power in sleep
// RQ2 - Low-power bit clear: regulator normal in sleep
// RQ3 - Firmware keeps reserved regulator bit 0 set
// RQ4 - Unimplemented register bits read as zero
// RQ5 - Idle select set: sleep gates CPU only
// RQ6 - Idle select clear: sleep enters full sleep
// RQ7 - Throttle active: CPU runs at ratio rate
// RQ8 - Throttle inactive: CPU runs every cycle
// RQ9 - Recover bit clears throttle on interrupt entry
// RQ10 - Recover bit clear: entry leaves throttle alone
// RQ11 - Throttle-on-return sets throttle at return
// RQ12 - Ratio code n selects one in 2^(n+1)
// RQ13 - Debug forces full speed, stored bit kept
// RQ14 - Any enabled interrupt ends idle, select kept
// RQ15 - Watchdog in idle wakes, recover not applied
// RQ16 - Low-power wake inserts stabilisation delay
// RQ17 - Throttle enables one cycle per ratio group
`timescale 1ns/1ps
`include "ctis_map.vh"

module ctis_ctrl (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // CPU core events
  input  wire       sleep_instr,
  input  wire       irq_entry,
  input  wire       return_from_interrupt_instr,
  input  wire       in_circuit_debug_entry,
  input  wire       irq_pending,
  input  wire       wdt_timeout,
  input  wire       ext_wake,
  // Clock enables and power controls
  output reg        cpu_clk_en,
  output reg        periph_clk_en,
  output reg        regulator_lowpower,
  output reg        wdt_reset_req,
  output reg        sleep_active,
  output reg        idle_active
);

  // One-hot sequencer states
  localparam [3:0] ST_RUN   = 4'b0001;
  localparam [3:0] ST_IDLE  = 4'b0010;
  localparam [3:0] ST_SLEEP = 4'b0100;
  localparam [3:0] ST_WAKE  = 4'b1000;

  localparam [7:0] WAKE_CYC = `CTIS_LP_WAKE_CYC;

  // Software fields of the two control registers, and the debug latch
  reg        lp_sel_q;
  reg        lp_sel_d;
  reg        idle_sel_q;
  reg        idle_sel_d;
  reg        thr_act_q;
  reg        thr_act_d;
  reg        roi_q;
  reg        roi_d;
  reg        doe_q;
  reg        doe_d;
  reg  [2:0] ratio_q;
  reg  [2:0] ratio_d;
  reg        dbg_q;
  reg        dbg_d;
  // Sleep / idle sequencer and throttle divider
  reg  [3:0] state_q;
  reg  [3:0] state_d;
  reg  [7:0] wake_cnt_q;
  reg  [7:0] wake_cnt_d;
  reg  [7:0] div_q;
  // Read data and the next values of the registered outputs
  reg  [7:0] rdata_d;
  reg        cpu_en_d;
  reg        periph_en_d;
  reg        lowpower_d;
  reg        wdt_req_d;
  reg        sleep_d;
  reg        idle_d;

  // Register port decode
  wire wr_reg = reg_wr && (reg_addr == `CTIS_OFF_REG_CTRL);
  wire wr_thr = reg_wr && (reg_addr == `CTIS_OFF_THR_CTRL);
  // Wake sources: ext_wake only ends full sleep, never idle
  wire idle_wake  = irq_pending || wdt_timeout;
  wire sleep_wake = idle_wake || ext_wake;

  // Mask of divider bits that must be zero to grant a CPU cycle
  function [7:0] ratio_mask;
    input [2:0] code;
    begin
      ratio_mask = (8'h02 << code) - 8'h01; // RQ12
    end
  endfunction

  // Full sleep and the low-power wake delay both stop the peripherals
  function dormant;
    input [3:0] st;
    begin
      dormant = (st == ST_SLEEP) || (st == ST_WAKE);
    end
  endfunction

  // One CPU grant per ratio group: it falls where the next divider value
  // has all masked bits clear; the peripherals still see every cycle.
  function grant_slot;
    input [7:0] div;
    input [2:0] code;
    begin
      grant_slot = ((div + 8'h01) & ratio_mask(code)) == 8'h00; // RQ17
    end
  endfunction

  // Throttle bit: write first, then hardware events override it, so an
  // entry or return in the same cycle as a write is not lost.
  always @* begin
    thr_act_d = thr_act_q; // RQ10
    if (wr_thr)
      thr_act_d = reg_wdata[`CTIS_THR_ACT_BIT];
    if (irq_entry && roi_q)
      thr_act_d = 1'b0; // RQ9
    else if (return_from_interrupt_instr && doe_q)
      thr_act_d = 1'b1; // RQ11
  end

  // Debug entry latches until reset. It only overrides the CPU enable;
  // the stored throttle bit stays as firmware or hardware left it.
  always @* begin
    dbg_d = dbg_q;
    if (in_circuit_debug_entry)
      dbg_d = 1'b1; // RQ13
  end

  // Plain software fields take the write data as it stands
  always @* begin
    lp_sel_d   = lp_sel_q;
    idle_sel_d = idle_sel_q;
    roi_d      = roi_q;
    doe_d      = doe_q;
    ratio_d    = ratio_q;
    if (wr_reg)
      lp_sel_d = reg_wdata[`CTIS_REG_LP_BIT]; // RQ1 RQ2
    if (wr_thr) begin
      idle_sel_d = reg_wdata[`CTIS_THR_IDLE_BIT]; // RQ5 RQ6
      roi_d      = reg_wdata[`CTIS_THR_ROI_BIT];
      doe_d      = reg_wdata[`CTIS_THR_DOE_BIT];
      ratio_d    = reg_wdata[`CTIS_THR_RATIO_HI:`CTIS_THR_RATIO_LO];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      lp_sel_q   <= 1'b0;
      idle_sel_q <= 1'b0;
      thr_act_q  <= 1'b0;
      roi_q      <= 1'b0;
      doe_q      <= 1'b0;
      ratio_q    <= 3'h0;
      dbg_q      <= 1'b0;
    end else begin
      lp_sel_q   <= lp_sel_d;
      idle_sel_q <= idle_sel_d;
      thr_act_q  <= thr_act_d;
      roi_q      <= roi_d;
      doe_q      <= doe_d;
      ratio_q    <= ratio_d;
      dbg_q      <= dbg_d;
    end
  end

  // Sleep / idle sequencing
  always @* begin
    state_d    = state_q;
    wake_cnt_d = wake_cnt_q;
    case (state_q)
      ST_RUN: begin
        if (sleep_instr) begin
          if (idle_sel_q)
            state_d = ST_IDLE; // RQ5
          else
            state_d = ST_SLEEP; // RQ6
        end
      end
      ST_IDLE: begin
        // Idle select is left as written so the next sleep re-enters idle
        if (idle_wake)
          state_d = ST_RUN; // RQ14 RQ15
      end
      ST_SLEEP: begin
        if (sleep_wake) begin
          if (lp_sel_q) begin
            state_d    = ST_WAKE; // RQ16
            wake_cnt_d = WAKE_CYC;
          end else begin
            // Normal regulator needs no settling time
            state_d = ST_RUN; // RQ2
          end
        end
      end
      ST_WAKE: begin
        // Regulator settling time runs out before the CPU restarts
        if (wake_cnt_q <= 8'h01)
          state_d = ST_RUN;
        wake_cnt_d = wake_cnt_q - 8'h01; // RQ16
      end
      default: state_d = ST_RUN;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_q    <= ST_RUN;
      wake_cnt_q <= 8'h00;
      div_q      <= 8'h00;
    end else begin
      state_q    <= state_d;
      wake_cnt_q <= wake_cnt_d;
      // Free-running clock cycle counter, counting through sleep too, paces the CPU grants
      div_q      <= div_q + 8'h01; // RQ17
    end
  end

  // Next values follow the next state so the enables change with it
  always @* begin
    // Debug wins over throttling but never over idle or sleep
    if (state_d != ST_RUN)
      cpu_en_d = 1'b0; // RQ5 RQ6
    else if (dbg_d || !thr_act_d)
      cpu_en_d = 1'b1; // RQ8 RQ13
    else
      cpu_en_d = grant_slot(div_q, ratio_q); // RQ7
    periph_en_d = !dormant(state_d); // RQ5
    lowpower_d  = (state_d == ST_SLEEP) && lp_sel_q; // RQ1 RQ2
    // Watchdog resets only outside idle and sleep; there it only wakes
    wdt_req_d   = wdt_timeout && (state_q == ST_RUN); // RQ15
    sleep_d     = dormant(state_d); // RQ6
    idle_d      = (state_d == ST_IDLE); // RQ5
  end

  // Outputs are registered so the clock gates see glitch-free enables
  always @(posedge clk) begin
    if (rst) begin
      cpu_clk_en         <= 1'b0;
      periph_clk_en      <= 1'b0;
      regulator_lowpower <= 1'b0;
      wdt_reset_req      <= 1'b0;
      sleep_active       <= 1'b0;
      idle_active        <= 1'b0;
    end else begin
      cpu_clk_en         <= cpu_en_d;
      periph_clk_en      <= periph_en_d;
      regulator_lowpower <= lowpower_d;
      wdt_reset_req      <= wdt_req_d;
      sleep_active       <= sleep_d;
      idle_active        <= idle_d;
    end
  end

  // Read data one cycle after the read strobe; zero otherwise
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `CTIS_OFF_REG_CTRL: begin
        rdata_d[`CTIS_REG_LP_BIT]   = lp_sel_q;
        rdata_d[`CTIS_REG_RSVD_BIT] = 1'b1; // RQ3 RQ4
      end
      `CTIS_OFF_THR_CTRL: begin
        rdata_d[`CTIS_THR_IDLE_BIT] = idle_sel_q;
        rdata_d[`CTIS_THR_ACT_BIT]  = thr_act_q;
        rdata_d[`CTIS_THR_ROI_BIT]  = roi_q;
        rdata_d[`CTIS_THR_DOE_BIT]  = doe_q;
        rdata_d[`CTIS_THR_RATIO_HI:`CTIS_THR_RATIO_LO] = ratio_q; // RQ4
      end
      `CTIS_OFF_STATUS: begin
        rdata_d[`CTIS_ST_RUN_BIT]   = state_q[0];
        rdata_d[`CTIS_ST_IDLE_BIT]  = state_q[1];
        rdata_d[`CTIS_ST_SLEEP_BIT] = state_q[2];
        rdata_d[`CTIS_ST_WAKE_BIT]  = state_q[3];
        rdata_d[`CTIS_ST_DBG_BIT]   = dbg_q;
      end
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 8'h00;
  end

endmodule // ctis_ctrl

/* File: test/ctis_checker.sv */
// Port-level assertions for the throttle / idle / sleep controller.
// Assumes it is bound to ctis_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module ctis_checker (
  input logic       clk, rst, reg_wr, reg_rd,
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata, reg_rdata,
  input logic       sleep_instr, irq_entry, in_circuit_debug_entry,
  input logic       return_from_interrupt_instr, irq_pending,
  input logic       wdt_timeout, ext_wake, cpu_clk_en, periph_clk_en,
  input logic       regulator_lowpower, wdt_reset_req,
  input logic       sleep_active, idle_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reg0_fixed: assert property (reg_rd && reg_addr == 4'h0 |=>
    reg_rdata[7:2] == 6'h00 && reg_rdata[0]) else $error("reg0 bits");
  a_reg1_gap: assert property (reg_rd && reg_addr == 4'h1 |=>
    !reg_rdata[3]) else $error("reg1 bit3");
  a_lp_in_sleep: assert property (regulator_lowpower |->
    sleep_active) else $error("lowpower out of sleep");
  a_idle_clocks: assert property (idle_active |->
    periph_clk_en && !cpu_clk_en) else $error("idle clocks");
  a_sleep_clocks: assert property (sleep_active |->
    !periph_clk_en && !cpu_clk_en && !idle_active) else $error("sleep");
  a_idle_entry: assert property ($rose(idle_active) |->
    $past(sleep_instr)) else $error("idle without sleep");
  a_idle_exit: assert property (idle_active && irq_pending |=>
    !idle_active) else $error("idle kept");
  a_wdt_blocked: assert property (idle_active && wdt_timeout |=>
    !idle_active && !wdt_reset_req) else $error("wdt in idle");
  a_debug_full: assert property (in_circuit_debug_entry && !sleep_instr
    && !idle_active && !sleep_active |=> cpu_clk_en [*8])
    else $error("debug not full speed");
endmodule // ctis_checker

/* File: test/ctis_cpu_model.sv */
// CPU core stand-in: turns bench requests into one-cycle event pulses.
// Assumes the bench raises each request for exactly one clock.
`timescale 1ns/1ps
module ctis_cpu_model (
  // Clock and bench requests
  input  logic       clk,
  input  logic [5:0] req,
  // Core events
  output logic       sleep_instr,
  output logic       irq_entry,
  output logic       return_from_interrupt_instr,
  output logic       in_circuit_debug_entry,
  output logic       wdt_timeout,
  output logic       ext_wake
);
  // Events leave one edge late, as an instruction retires
  logic [5:0] ev_q = 6'h00;
  always @(posedge clk)
    ev_q <= req;
  assign {ext_wake, wdt_timeout, in_circuit_debug_entry,
          return_from_interrupt_instr, irq_entry, sleep_instr} = ev_q;
endmodule // ctis_cpu_model

/* File: test/testbench.sv */
// Self-checking bench for ctis_ctrl with the CPU core model.
// Assumes a 25 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
module testbench;
  logic       clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, irq_pending = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [5:0] req = 6'h00;
  logic       sleep_instr, irq_entry, return_from_interrupt_instr;
  logic       in_circuit_debug_entry, wdt_timeout, ext_wake, cpu_clk_en;
  logic       periph_clk_en, regulator_lowpower, wdt_reset_req;
  logic       sleep_active, idle_active;
  int         errors = 0, total_checks = 0, i;
  ctis_ctrl ctis_ctrl_i (.*);
  ctis_cpu_model ctis_cpu_model_i (.*);
  initial forever #20 clk = ~clk;
  task automatic end_sim;
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic ev(input logic [5:0] e);
    @(posedge clk) req <= e;
    @(posedge clk) req <= 6'h00;
  endtask
  task automatic cnt(input int n, input int e);
    int c = 0;
    int p = 0;
    repeat (3) @(posedge clk);
    repeat (n) begin
      tick(1);
      c += (cpu_clk_en === 1'b1);
      p += (periph_clk_en === 1'b1);
    end
    chk(c, e);
    chk(p, n);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 8'h01);
    rd(4'h1, 8'h00);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h03);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'hf7);
    rd(4'h5, 8'h00);
    for (i = 0; i < 8; i++) begin
      wr(4'h1, 8'h40 | i[7:0]);
      cnt(512, 512 >> (i + 1));
    end
    wr(4'h1, 8'h07);
    cnt(64, 64);
    wr(4'h1, 8'h47);
    ev(6'h02);
    rd(4'h1, 8'h47);
    wr(4'h1, 8'h67);
    ev(6'h02);
    rd(4'h1, 8'h27);
    wr(4'h1, 8'h17);
    ev(6'h04);
    rd(4'h1, 8'h57);
    wr(4'h1, 8'h07);
    ev(6'h04);
    rd(4'h1, 8'h07);
    wr(4'h1, 8'h80);
    ev(6'h01);
    tick(2);
    chk({idle_active, periph_clk_en, cpu_clk_en}, 3'b110);
    rd(4'h2, 8'h02);
    @(posedge clk) irq_pending <= 1'b1;
    tick(2);
    chk(idle_active, 1'b0);
    @(posedge clk) irq_pending <= 1'b0;
    rd(4'h1, 8'h80);
    ev(6'h01);
    ev(6'h10);
    tick(1);
    chk({idle_active, wdt_reset_req}, 2'b00);
    ev(6'h10);
    tick(1);
    chk(wdt_reset_req, 1'b1);
    for (i = 0; i < 2; i++) begin
      wr(4'h0, {6'h00, i[0], 1'b1});
      wr(4'h1, 8'h00);
      ev(6'h01);
      tick(2);
      chk({sleep_active, regulator_lowpower, periph_clk_en},
          {1'b1, i[0], 1'b0});
      ev(6'h20);
      tick(10);
      chk(sleep_active, i[0]);
      tick(40);
      chk(sleep_active, i[0]);
      tick(1);
      chk(sleep_active, 1'b0);
      tick(20);
    end
    wr(4'h1, 8'h47);
    ev(6'h08);
    cnt(64, 64);
    rd(4'h1, 8'h47);
    rd(4'h2, 8'h11);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(4'h2, 8'h01);
    rd(4'h1, 8'h00);
    rd(4'h0, 8'h01);
    cnt(16, 16);
    end_sim;
  end
  // Tests need about 4500 cycles; give them a wide margin
  initial begin
    #1000000;
    errors++;
    end_sim;
  end
endmodule // testbench
bind ctis_ctrl ctis_checker ctis_checker_i (.*);
